// >>> design/lpl_polarity_link.sv
// Purpose: Per-channel pin polarity, duty-mirror follow and linked-LED transition logic.
// Assumes: Touch, link, drive and duty inputs come from logic on core_clk.
// Notes:   The duty ramp itself is produced outside; this block shapes the pin.
module lpl_polarity_link (
  input  wire logic        core_clk,                      // System clock, 100 MHz.
  input  wire logic        reset_n,                       // Synchronous reset, active low.
  input  wire logic        clk_en,                        // Freezes all state while low.
  input  wire logic        reg_wr,                        // Register write strobe.
  input  wire logic        reg_rd,                        // Register read strobe.
  input  wire logic [7:0]  reg_addr,                      // Register byte address.
  input  wire logic [7:0]  reg_wdata,                     // Register write data.
  output logic      [7:0]  reg_rdata,                     // Registered read data.
  input  wire logic [10:0] channel_output_drive,          // Host drive bit per channel.
  input  wire logic [10:0] sensor_link,                   // Sensor link bit per channel.
  input  wire logic [10:0] touch_detect,                  // Touch present per channel.
  input  wire logic [10:0] channel_breathe,               // Non-direct behaviour selected.
  input  wire logic [10:0] output_push_pull,              // One for push-pull, zero open-drain.
  input  wire logic        block_polarity_mirror_follow,  // Blocks polarity-to-mirror copy.
  input  wire logic        invert_linked_transition,      // Linked transition invert control.
  input  wire logic [6:0]  duty_min,                      // Minimum duty in percent.
  input  wire logic [6:0]  duty_max,                      // Maximum duty in percent.
  input  wire logic [6:0]  ramp_duty,                     // Current breathe duty in percent.
  output logic      [10:0] channel_duty_mirror,           // Mirror bits to load.
  output logic             channel_duty_mirror_load,      // Pulse: load mirror bits.
  output logic      [10:0] channel_polarity,              // Current polarity bits.
  output logic      [10:0] led_actuated,                  // Effective actuation per channel.
  output logic      [10:0] led_pin_out,                   // Pin output value.
  output logic      [10:0] led_pin_oe                     // Pin output enable, high drives.
);

  logic [10:0] channel_polarity_r;
  logic [10:0] channel_polarity_nxt;
  logic [10:0] channel_link_transition_r;
  logic [10:0] channel_link_transition_nxt;
  logic [10:0] mirror_r;
  logic        mirror_load_r;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic [6:0]  phase_r;
  logic [10:0] link_prev_r;
  logic [10:0] pin_level_r;
  logic [10:0] pin_oe_r;
  logic [10:0] pin_out_r;

  wire logic wr_pol_lo  = reg_wr && (reg_addr == lpl_pkg::LED_POLARITY_LOW_ADDR);
  wire logic wr_pol_hi  = reg_wr && (reg_addr == lpl_pkg::LED_POLARITY_HIGH_ADDR);
  wire logic wr_tran_lo = reg_wr && (reg_addr == lpl_pkg::LINK_TRANSITION_LOW_ADDR);
  wire logic wr_tran_hi = reg_wr && (reg_addr == lpl_pkg::LINK_TRANSITION_HIGH_ADDR);
  wire logic pol_write  = wr_pol_lo || wr_pol_hi;

  // Split a register write into the channel vector; unwritten halves keep their value.
  function automatic logic [10:0] merge_bits(input logic [10:0] cur,
                                             input logic        wr_lo,
                                             input logic        wr_hi,
                                             input logic [7:0]  lo_mask,
                                             input logic [7:0]  hi_mask,
                                             input logic [7:0]  data);
    logic [10:0] res;
    res = cur;
    if (wr_lo) begin
      res[7:0] = data & lo_mask;
    end
    if (wr_hi) begin
      res[10:8] = data[2:0] & hi_mask[2:0];
    end
    return res;
  endfunction

  // Next register values; reserved bits are masked so they read back as zero.
  assign channel_polarity_nxt = merge_bits(channel_polarity_r, wr_pol_lo, wr_pol_hi,
                                           8'hFF, lpl_pkg::POL_HIGH_MASK, reg_wdata);
  // The low mask keeps LED8 out and the high mask LED11; a write can clear bits as well as set them.
  assign channel_link_transition_nxt = merge_bits(channel_link_transition_r, wr_tran_lo,
                                                  wr_tran_hi, lpl_pkg::TRAN_LOW_MASK,
                                                  lpl_pkg::TRAN_HIGH_MASK, reg_wdata);

  // Read mux; unmapped addresses answer zero.
  always_comb begin
    unique case (reg_addr)
      lpl_pkg::LED_POLARITY_LOW_ADDR:     rdata_nxt = channel_polarity_r[7:0];
      lpl_pkg::LED_POLARITY_HIGH_ADDR:    rdata_nxt = {5'h00, channel_polarity_r[10:8]};
      lpl_pkg::LINK_TRANSITION_LOW_ADDR:  rdata_nxt = {1'b0, channel_link_transition_r[6:0]};
      lpl_pkg::LINK_TRANSITION_HIGH_ADDR: rdata_nxt = {6'h00, channel_link_transition_r[9:8]};
      default:                            rdata_nxt = lpl_pkg::REG_RESET;
    endcase
  end

  // Register file and mirror follow. The mirror copy takes the whole polarity vector,
  // so a write that leaves a bit unchanged still re-asserts its mirror value.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      channel_polarity_r        <= 11'h000;
      channel_link_transition_r <= 11'h000;
      mirror_r                  <= 11'h000;
      mirror_load_r             <= 1'b0;
      rdata_r                   <= lpl_pkg::REG_RESET;
    end else if (clk_en) begin
      channel_polarity_r        <= channel_polarity_nxt;
      channel_link_transition_r <= channel_link_transition_nxt;
      mirror_load_r             <= pol_write && !block_polarity_mirror_follow;
      if (pol_write && !block_polarity_mirror_follow) begin
        mirror_r <= channel_polarity_nxt;
      end
      if (reg_rd) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // Shared percent phase counter for every channel's pin waveform.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      phase_r     <= lpl_pkg::PHASE_ZERO;
      link_prev_r <= 11'h000;
    end else if (clk_en) begin
      phase_r     <= (phase_r == lpl_pkg::PHASE_LAST) ? lpl_pkg::PHASE_ZERO : phase_r + 7'h01;
      link_prev_r <= sensor_link & lpl_pkg::LINKABLE_MASK;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < lpl_pkg::CHANNELS; ch++) begin : g_chan
      lpl_pkg::lpl_link_mode_t mode_r;
      lpl_pkg::lpl_link_mode_t mode_nxt;
      logic [6:0]              on_duty;
      logic [6:0]              high_duty;
      logic                    act;
      logic                    level;
      wire logic linked    = sensor_link[ch] && lpl_pkg::LINKABLE_MASK[ch];
      wire logic link_rise = linked && !link_prev_r[ch];
      wire logic held_on   = channel_output_drive[ch] && !touch_detect[ch];

      // Hand-over mode is fixed at the link edge from the drive bit held then.
      always_comb begin
        mode_nxt = mode_r;
        if (link_rise) begin
          if (held_on && channel_link_transition_r[ch]) begin
            mode_nxt = invert_linked_transition ? lpl_pkg::LPL_INVERT
                                                : lpl_pkg::LPL_HOLD;
          end else begin
            mode_nxt = lpl_pkg::LPL_FOLLOW;
          end
        end
      end

      // Actuation: unlinked follows the drive bit; linked follows the touch in follow mode, its inverse in invert mode, stays on in hold mode.
      always_comb begin
        unique case (mode_r)
          lpl_pkg::LPL_INVERT: act = linked ? !touch_detect[ch] : channel_output_drive[ch];
          lpl_pkg::LPL_HOLD:   act = linked ? 1'b1 : channel_output_drive[ch];
          default:             act = linked ? touch_detect[ch] : channel_output_drive[ch];
        endcase
      end

      // LED-on duty: idle at minimum, breathe on the ramp, direct at maximum when actuated.
      assign on_duty   = !act ? duty_min :
                         channel_breathe[ch] ? ramp_duty : duty_max;
      // Non-inverted channels place the same on-time as 100 minus the setting high.
      assign high_duty = lpl_pkg::DUTY_FULL - on_duty;

      // Pin level; the mirror bits are deliberately not used here.
      always_comb begin
        if (act && !channel_breathe[ch]) begin
          level = channel_polarity_r[ch];
        end else if (channel_polarity_r[ch]) begin
          level = (phase_r < high_duty);
        end else begin
          level = !(phase_r < on_duty);
        end
      end

      // Registered pin drive; open-drain only drives when pulling low.
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          mode_r          <= lpl_pkg::LPL_FOLLOW;
          pin_level_r[ch] <= 1'b0;
          pin_oe_r[ch]    <= 1'b0;
          pin_out_r[ch]   <= 1'b0;
        end else if (clk_en) begin
          mode_r          <= mode_nxt;
          pin_level_r[ch] <= act;
          pin_oe_r[ch]    <= output_push_pull[ch] || !level;
          pin_out_r[ch]   <= output_push_pull[ch] && level;
        end
      end
    end
  endgenerate

  assign reg_rdata                = rdata_r;
  assign channel_duty_mirror      = mirror_r;
  assign channel_duty_mirror_load = mirror_load_r;
  assign channel_polarity         = channel_polarity_r;
  assign led_actuated             = pin_level_r;
  assign led_pin_out              = pin_out_r;
  assign led_pin_oe               = pin_oe_r;

endmodule

// >>> design/lpl_pkg.sv
// Purpose: Shared constants for the LED polarity and linked-transition block.
// Assumes: Eleven LED channels, duty settings given in whole percent.
// Notes:   Register offsets are byte addresses on the device register port.
package lpl_pkg;
  localparam int unsigned CHANNELS = 11;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned DUTY_W   = 7;

  // Register offsets.
  localparam logic [7:0] LED_POLARITY_LOW_ADDR      = 8'h75;
  localparam logic [7:0] LED_POLARITY_HIGH_ADDR     = 8'h76;
  localparam logic [7:0] LINK_TRANSITION_LOW_ADDR   = 8'h77;
  localparam logic [7:0] LINK_TRANSITION_HIGH_ADDR  = 8'h78;

  // Reset values and writable masks.
  localparam logic [7:0] REG_RESET          = 8'h00;
  localparam logic [7:0] POL_HIGH_MASK      = 8'h07;
  localparam logic [7:0] TRAN_LOW_MASK      = 8'h7F;
  localparam logic [7:0] TRAN_HIGH_MASK     = 8'h03;

  // Field positions and widths: channel index of each high register's low bit, and bits per field.
  localparam int unsigned POL_HIGH_BASE  = 8;
  localparam int unsigned TRAN_HIGH_BASE = 8;
  localparam int unsigned POL_HIGH_BITS  = 3;
  localparam int unsigned TRAN_LOW_BITS  = 7;
  localparam int unsigned TRAN_HIGH_BITS = 2;

  // Channels that can be tied to a sensor (LED1..LED7, LED9, LED10).
  localparam logic [10:0] LINKABLE_MASK = 11'h37F;

  // Duty cycle period in percent steps.
  localparam logic [6:0] DUTY_FULL  = 7'h64;
  localparam logic [6:0] PHASE_LAST = 7'h63;
  localparam logic [6:0] PHASE_ZERO = 7'h00;

  // Link hand-over mode captured when a sensor link is made.
  typedef enum logic [2:0] {
    LPL_FOLLOW = 3'b001,
    LPL_INVERT = 3'b010,
    LPL_HOLD   = 3'b100
  } lpl_link_mode_t;
endpackage

// >>> tb/lpl_led_model.sv
// Purpose: External LEDs on the eleven pins, pull-ups on the open-drain lines.
// Assumes: LED tied to supply, so a low pin lights it.
// Notes:   A released pin reads high through its pull-up, never a held value.
module lpl_led_model (
  input  wire logic [10:0] led_pin_out,  // Pin value from the block.
  input  wire logic [10:0] led_pin_oe,   // High while the block drives.
  output logic      [10:0] pin_level,    // Resolved wire level.
  output logic      [10:0] led_lit       // High while current flows.
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released lines float up to the pull-up level.
  assign pin_level = (led_pin_out & led_pin_oe) | ~led_pin_oe;
  assign led_lit   = ~pin_level;
endmodule

// >>> tb/lpl_chk.sv
// Purpose: Port checks for the polarity and link block.
// Assumes: clk_en held high by the bench.
// Notes:   Channel 0 stands for all channels to keep the checks short.
module lpl_chk (
  input wire logic        core_clk,                      // Clock.
  input wire logic        reset_n,                       // Reset, active low.
  input wire logic        reg_wr,                        // Write strobe.
  input wire logic        reg_rd,                        // Read strobe.
  input wire logic [7:0]  reg_addr,                      // Address.
  input wire logic [7:0]  reg_wdata,                     // Write data.
  input wire logic [7:0]  reg_rdata,                     // Read data.
  input wire logic [10:0] channel_output_drive,          // Drive bits.
  input wire logic [10:0] sensor_link,                   // Link bits.
  input wire logic [10:0] touch_detect,                  // Touch bits.
  input wire logic [10:0] channel_breathe,               // Breathe select.
  input wire logic [10:0] output_push_pull,              // Output type.
  input wire logic        block_polarity_mirror_follow,  // Mirror block.
  input wire logic [10:0] channel_duty_mirror,           // Mirror bits.
  input wire logic        channel_duty_mirror_load,      // Mirror load.
  input wire logic [10:0] channel_polarity,              // Polarity bits.
  input wire logic [10:0] led_actuated,                  // Actuation.
  input wire logic [10:0] led_pin_out,                   // Pin value.
  input wire logic [10:0] led_pin_oe                     // Pin enable.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Either polarity register counts as a polarity write.
  wire logic pol_wr = reg_wr && (reg_addr == 8'h75 || reg_addr == 8'h76);
  // A link made while the host drive is off hands over in follow mode.
  sequence link_rise_idle;
    !sensor_link[0] ##1 sensor_link[0] && !channel_output_drive[0];
  endsequence
  mirror_load_a : assert property (
    pol_wr && !block_polarity_mirror_follow |=>
    channel_duty_mirror_load && channel_duty_mirror == channel_polarity) else $error("no mirror load");
  mirror_block_a : assert property (
    pol_wr && block_polarity_mirror_follow |=> !channel_duty_mirror_load) else $error("mirror loaded");
  pol_write_a : assert property (
    reg_wr && reg_addr == 8'h75 |=> channel_polarity[7:0] == $past(reg_wdata)) else $error("pol write");
  pol_read_a : assert property (
    reg_rd && !reg_wr && reg_addr == 8'h76 |=>
    reg_rdata == {5'h00, $past(channel_polarity[10:8])}) else $error("pol read");
  inv_drive_a : assert property (
    led_actuated[0] && !$past(channel_polarity[0]) && !$past(channel_breathe[0]) |->
    led_pin_oe[0] && !led_pin_out[0]) else $error("inverted pin not low");
  pp_high_a : assert property (
    led_actuated[0] && $past(channel_polarity[0]) && !$past(channel_breathe[0]) &&
    $past(output_push_pull[0]) |-> led_pin_oe[0] && led_pin_out[0]) else $error("pin not high");
  od_release_a : assert property (
    led_actuated[0] && $past(channel_polarity[0]) && !$past(channel_breathe[0]) &&
    !$past(output_push_pull[0]) |-> !led_pin_oe[0]) else $error("pin not released");
  unlinked_act_a : assert property (
    !sensor_link[0] |=> led_actuated[0] == $past(channel_output_drive[0])) else $error("unlinked act");
  follow_touch_a : assert property (
    link_rise_idle ##1 sensor_link[0] |=> led_actuated[0] == $past(touch_detect[0]))
    else $error("touch not followed");
endmodule

bind lpl_polarity_link lpl_chk u_chk (.*);

// >>> tb/tb.sv
// Purpose: Self-checking bench for the polarity and link block.
// Assumes: Channel 0 carries the pin and link scenarios.
// Notes:   Duty counts span one full 100-cycle period.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic block_polarity_mirror_follow = 1'b0, invert_linked_transition = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [10:0] channel_output_drive = 11'h000, sensor_link = 11'h000, touch_detect = 11'h000;
  logic [10:0] channel_breathe = 11'h000, output_push_pull = 11'h000, channel_duty_mirror;
  logic [10:0] channel_polarity, led_actuated, led_pin_out, led_pin_oe, pin_level, led_lit;
  logic channel_duty_mirror_load;
  logic [6:0] duty_min = 7'h1E, duty_max = 7'h50, ramp_duty = 7'h28;
  int fails = 0, checks_done = 0, cycles = 0;
  lpl_polarity_link dut (.*);
  lpl_led_model led (.*);
  always #5 core_clk = ~core_clk;
  // Cut a hang short well past the expected run length.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      finish_test();
    end
  end
  task automatic cmp(string what, logic [10:0] exp, logic [10:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 cmp("reg_rdata", {3'h0, exp}, {3'h0, reg_rdata});
  endtask
  // Count cycles with pin 0 high over one period.
  task automatic duty(string what, int exp);
    int n;
    n = 0;
    repeat (100) begin
      @(posedge core_clk);
      #1 n += int'(pin_level[0]);
    end
    cmp(what, 11'(exp), 11'(n));
  endtask
  task automatic t_regs();
    rd_chk(8'h75, 8'h00);
    rd_chk(8'h78, 8'h00);
    wr(8'h76, 8'hFF);
    rd_chk(8'h76, 8'h07);
    wr(8'h77, 8'hFF);
    rd_chk(8'h77, 8'h7F);
    wr(8'h78, 8'hFF);
    rd_chk(8'h78, 8'h03);
    wr(8'h78, 8'h00);
    rd_chk(8'h78, 8'h00);
    wr(8'h79, 8'hFF);
    rd_chk(8'h79, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_mirror();
    @(posedge core_clk);
    block_polarity_mirror_follow <= 1'b1;
    wr(8'h75, 8'h5A);
    #1 cmp("mirror_load", 11'h000, {10'h000, channel_duty_mirror_load});
    @(posedge core_clk);
    block_polarity_mirror_follow <= 1'b0;
    wr(8'h75, 8'hA5);
    #1 cmp("mirror_load", 11'h001, {10'h000, channel_duty_mirror_load});
    cmp("mirror", 11'h7A5, channel_duty_mirror);
    $display("test mirror done");
  endtask
  task automatic t_pins();
    for (int p = 0; p < 2; p++) begin
      for (int q = 0; q < 2; q++) begin
        wr(8'h75, {7'h00, p[0]});
        output_push_pull <= {10'h000, q[0]};
        channel_output_drive <= 11'h001;
        repeat (3) @(posedge core_clk);
        #1 cmp("pin_level", {10'h000, p[0]}, {10'h000, pin_level[0]});
        cmp("pin_oe", {10'h000, !(p[0] && !q[0])}, {10'h000, led_pin_oe[0]});
        @(posedge core_clk);
        channel_output_drive <= 11'h000;
        repeat (3) @(posedge core_clk);
        duty("idle_high", 70);
      end
    end
    wr(8'h75, 8'h00);
    channel_breathe <= 11'h001;
    invert_linked_transition <= 1'b1;
    channel_output_drive <= 11'h001;
    repeat (3) @(posedge core_clk);
    duty("breathe_high", 60);
    @(posedge core_clk);
    channel_breathe <= 11'h000;
    $display("test pins done");
  endtask
  task automatic t_link();
    // Each entry: drive, transition, invert, act linked touch-free, act touched.
    logic [4:0] tab [4] = '{5'b10001, 5'b11110, 5'b11011, 5'b01101};
    foreach (tab[i]) begin
      @(posedge core_clk);
      invert_linked_transition <= tab[i][2];
      wr(8'h77, {7'h00, tab[i][3]});
      channel_output_drive <= {10'h000, tab[i][4]};
      repeat (3) @(posedge core_clk);
      #1 cmp("act_host", {10'h000, tab[i][4]}, {10'h000, led_actuated[0]});
      @(posedge core_clk);
      sensor_link <= 11'h001;
      repeat (3) @(posedge core_clk);
      #1 cmp("act_linked", {10'h000, tab[i][1]}, {10'h000, led_actuated[0]});
      @(posedge core_clk);
      touch_detect <= 11'h001;
      repeat (3) @(posedge core_clk);
      #1 cmp("act_touch", {10'h000, tab[i][0]}, {10'h000, led_actuated[0]});
      @(posedge core_clk);
      touch_detect <= 11'h000;
      sensor_link <= 11'h000;
    end
    $display("test link done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Reset for four cycles, then run the scenarios in turn.
  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    t_regs();
    t_mirror();
    t_pins();
    t_link();
    finish_test();
  end
endmodule
